// ### src/dcc_pkg.sv
`default_nettype none

package dcc_pkg;

	// register addresses on the special-function-register bus
	localparam logic [7:0] DCC_ADDR_CTRL1  = 8'h9a;
	localparam logic [7:0] DCC_ADDR_CTRL0  = 8'h9b;
	localparam logic [7:0] DCC_ADDR_MODE1  = 8'h9c;
	localparam logic [7:0] DCC_ADDR_MODE0  = 8'h9d;
	localparam logic [7:0] DCC_ADDR_INSEL0 = 8'h9f;
	localparam logic [7:0] DCC_ADDR_INSEL1 = 8'h9e;

	// control register fields
	localparam int DCC_CTL_EN_BIT   = 7;
	localparam int DCC_CTL_OUT_BIT  = 6;
	localparam int DCC_CTL_RISE_BIT = 5;
	localparam int DCC_CTL_FALL_BIT = 4;
	localparam int DCC_CTL_HYP_LSB  = 2;
	localparam int DCC_CTL_HYN_LSB  = 0;

	// mode register fields
	localparam int DCC_MD_RIE_BIT  = 5;
	localparam int DCC_MD_FIE_BIT  = 4;
	localparam int DCC_MD_RESP_LSB = 0;

	// input select fields
	localparam int DCC_MX_NEG_LSB = 4;
	localparam int DCC_MX_POS_LSB = 0;

	// reset values
	localparam logic [7:0] DCC_CTRL_RST  = 8'h00;
	localparam logic [7:0] DCC_MODE_RST  = 8'h02;
	localparam logic [7:0] DCC_INSEL_RST = 8'hff;

	// mode register writable bits
	localparam logic [7:0] DCC_MODE_WMASK = 8'h33;

	// pin index spaces: 24 port pins, 0..7 port 0, 8..15 port 1, 16..23 port 2
	localparam int DCC_PIN_COUNT = 24;

	// hysteresis amounts in millivolts
	localparam logic [4:0] DCC_HYS_OFF  = 5'h00;
	localparam logic [4:0] DCC_HYS_5MV  = 5'h05;
	localparam logic [4:0] DCC_HYS_10MV = 5'h0a;
	localparam logic [4:0] DCC_HYS_20MV = 5'h14;

	// settings handed to one analog comparator
	typedef struct packed {
		logic       enable;
		logic [1:0] responseMode;
		logic [4:0] hysPosMv;
		logic [4:0] hysNegMv;
		logic [4:0] posPinIdx;
		logic [4:0] negPinIdx;
		logic       posValid;
		logic       negValid;
	} dcc_analog_cfg_t;

	// digital results of one comparator
	typedef struct packed {
		logic latchedOut;
		logic rawOut;
		logic irqReq;
		logic wakeReq;
	} dcc_result_t;

endpackage

`default_nettype wire

// ### src/dcc_channel.sv
`timescale 1ns/1ps
`default_nettype none

module dcc_channel
	import dcc_pkg::*;
(
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	input  wire logic             analogResult,
	input  wire logic [7:0]       ctrlWrData,
	input  wire logic             ctrlWr,
	input  wire logic [7:0]       modeWrData,
	input  wire logic             modeWr,
	input  wire logic [7:0]       inselWrData,
	input  wire logic             inselWr,
	output logic      [7:0]       ctrlRd,
	output logic      [7:0]       modeRd,
	output logic      [7:0]       inselRd,
	output dcc_analog_cfg_t       analogCfg,
	output dcc_result_t           result
);

	function automatic logic [4:0] hysDecode(input logic [1:0] code);
		unique case (code)
			2'h0: hysDecode = DCC_HYS_OFF;
			2'h1: hysDecode = DCC_HYS_5MV;
			2'h2: hysDecode = DCC_HYS_10MV;
			2'h3: hysDecode = DCC_HYS_20MV;
		endcase
	endfunction

	// code 0..11 -> pin index; odd selects the odd pins of each port
	function automatic logic [4:0] pinDecode(input logic [3:0] code, input logic odd);
		logic [4:0] port;
		logic [4:0] pos;
		port = {3'h0, code[3:2]};
		pos  = {2'h0, code[1:0], odd};
		pinDecode = 5'((port << 3) + pos);
	endfunction

	logic       enable_q;
	logic       riseFlag_q;
	logic       fallFlag_q;
	logic [1:0] hysPos_q;
	logic [1:0] hysNeg_q;
	logic       rie_q;
	logic       fie_q;
	logic [1:0] resp_q;
	logic [7:0] insel_q;
	logic       sync1_q;
	logic       sync2_q;
	logic       prev_q;
	logic       latched_q;
	logic       riseEdge;
	logic       fallEdge;
	logic       gatedRaw;

	// comparator output is low while disabled
	assign gatedRaw = analogResult & enable_q;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			enable_q <= DCC_CTRL_RST[DCC_CTL_EN_BIT];
			hysPos_q <= DCC_CTRL_RST[DCC_CTL_HYP_LSB +: 2];
			hysNeg_q <= DCC_CTRL_RST[DCC_CTL_HYN_LSB +: 2];
		end else if (ctrlWr) begin
			enable_q <= ctrlWrData[DCC_CTL_EN_BIT];
			hysPos_q <= ctrlWrData[DCC_CTL_HYP_LSB +: 2];
			hysNeg_q <= ctrlWrData[DCC_CTL_HYN_LSB +: 2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rie_q  <= DCC_MODE_RST[DCC_MD_RIE_BIT];
			fie_q  <= DCC_MODE_RST[DCC_MD_FIE_BIT];
			resp_q <= DCC_MODE_RST[DCC_MD_RESP_LSB +: 2];
		end else if (modeWr) begin
			rie_q  <= modeWrData[DCC_MD_RIE_BIT];
			fie_q  <= modeWrData[DCC_MD_FIE_BIT];
			resp_q <= modeWrData[DCC_MD_RESP_LSB +: 2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			insel_q <= DCC_INSEL_RST;
		end else if (inselWr) begin
			insel_q <= inselWrData;
		end
	end

	// two-stage synchroniser, then edge compare
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sync1_q   <= 1'h0;
			sync2_q   <= 1'h0;
			prev_q    <= 1'h0;
			latched_q <= 1'h0;
		end else begin
			sync1_q   <= gatedRaw;
			sync2_q   <= sync1_q;
			prev_q    <= sync2_q;
			latched_q <= sync2_q;
		end
	end

	assign riseEdge = sync2_q & ~prev_q;
	assign fallEdge = ~sync2_q & prev_q;

	// set wins over a software write; no hardware clear
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			riseFlag_q <= DCC_CTRL_RST[DCC_CTL_RISE_BIT];
			fallFlag_q <= DCC_CTRL_RST[DCC_CTL_FALL_BIT];
		end else begin
			if (riseEdge) begin
				riseFlag_q <= 1'h1;
			end else if (ctrlWr) begin
				riseFlag_q <= ctrlWrData[DCC_CTL_RISE_BIT];
			end
			if (fallEdge) begin
				fallFlag_q <= 1'h1;
			end else if (ctrlWr) begin
				fallFlag_q <= ctrlWrData[DCC_CTL_FALL_BIT];
			end
		end
	end

	always_comb begin
		ctrlRd = 8'h00;
		ctrlRd[DCC_CTL_EN_BIT]           = enable_q;
		ctrlRd[DCC_CTL_OUT_BIT]          = sync2_q;
		ctrlRd[DCC_CTL_RISE_BIT]         = riseFlag_q;
		ctrlRd[DCC_CTL_FALL_BIT]         = fallFlag_q;
		ctrlRd[DCC_CTL_HYP_LSB +: 2]     = hysPos_q;
		ctrlRd[DCC_CTL_HYN_LSB +: 2]     = hysNeg_q;
	end

	always_comb begin
		modeRd = 8'h00;
		modeRd[DCC_MD_RIE_BIT]           = rie_q;
		modeRd[DCC_MD_FIE_BIT]           = fie_q;
		modeRd[DCC_MD_RESP_LSB +: 2]     = resp_q;
	end

	assign inselRd = insel_q;

	always_comb begin
		analogCfg.enable       = enable_q;
		analogCfg.responseMode = resp_q;
		analogCfg.hysPosMv     = hysDecode(hysPos_q);
		analogCfg.hysNegMv     = hysDecode(hysNeg_q);
		analogCfg.negPinIdx    = pinDecode(insel_q[DCC_MX_NEG_LSB +: 4], 1'h1);
		analogCfg.posPinIdx    = pinDecode(insel_q[DCC_MX_POS_LSB +: 4], 1'h0);
		analogCfg.negValid     = ~(insel_q[DCC_MX_NEG_LSB + 3] & insel_q[DCC_MX_NEG_LSB + 2]);
		analogCfg.posValid     = ~(insel_q[DCC_MX_POS_LSB + 3] & insel_q[DCC_MX_POS_LSB + 2]);
	end

	// all uses of the result are available together
	always_comb begin
		result.latchedOut = latched_q;
		result.rawOut     = gatedRaw;
		result.irqReq     = (riseFlag_q & rie_q) | (fallFlag_q & fie_q);
		result.wakeReq    = enable_q & ~sync2_q;
	end

endmodule

`default_nettype wire

// ### src/dual_comparator_control.sv
// How it works
// - two identical comparator channels; only channel zero feeds reset source
// - each channel gives a latched output and a raw clockless output
// - input select upper nibble picks negative pin, lower nibble positive
// - negative codes 0..11 map to odd pins of ports 0,1,2; 11xx reserved
// - positive codes 0..11 map to even pins of ports 0,1,2; 11xx reserved
// - disabled comparator drives its routed output low
// - high to low output transition sets falling flag
// - low to high output transition sets rising flag
// - edge flags stay set until software writes zero
// - control bit 6 reads current comparator result, read only
// - control bit 7 enables or disables the comparator
// - enabled comparator with low output requests oscillator wake
// - interrupt on rising, falling or both edges
// - control bits 3..2 positive hysteresis: off, 5, 10, 20 mV
// - control bits 1..0 negative hysteresis, same decode
// - rising flag bit 5, falling flag bit 4, software read/write
// - result serves polling, interrupt, wake and port output at once
// - mode bit 5 rising interrupt enable, bit 4 falling enable
// - mode bits 1..0 response mode; mode resets to 0x02

`timescale 1ns/1ps
`default_nettype none

module dual_comparator_control
	import dcc_pkg::*;
(
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	input  wire logic [7:0]       sfrAddr,
	input  wire logic             sfrWr,
	input  wire logic [7:0]       sfrWrData,
	output logic      [7:0]       sfrRdData,
	input  wire logic             analogResult0,
	input  wire logic             analogResult1,
	output dcc_analog_cfg_t       analogCfg0,
	output dcc_analog_cfg_t       analogCfg1,
	output logic                  latched_output_zero,
	output logic                  raw_output_zero,
	output logic                  latched_output_one,
	output logic                  raw_output_one,
	output logic                  comparatorIrq0,
	output logic                  comparatorIrq1,
	output logic                  oscWakeReq,
	output logic                  resetSourceOut
);

	logic [7:0]  ctrlRd0;
	logic [7:0]  ctrlRd1;
	logic [7:0]  modeRd0;
	logic [7:0]  modeRd1;
	logic [7:0]  inselRd0;
	logic [7:0]  inselRd1;
	dcc_result_t res0;
	dcc_result_t res1;
	logic [7:0]  rdData_q;

	// two identical channels
	dcc_channel u_chan0 (
		.clk_sys     (clk_sys),
		.sys_rst     (sys_rst),
		.analogResult(analogResult0),
		.ctrlWrData  (sfrWrData),
		.ctrlWr      (sfrWr && (sfrAddr == DCC_ADDR_CTRL0)),
		.modeWrData  (sfrWrData & DCC_MODE_WMASK),
		.modeWr      (sfrWr && (sfrAddr == DCC_ADDR_MODE0)),
		.inselWrData (sfrWrData),
		.inselWr     (sfrWr && (sfrAddr == DCC_ADDR_INSEL0)),
		.ctrlRd      (ctrlRd0),
		.modeRd      (modeRd0),
		.inselRd     (inselRd0),
		.analogCfg   (analogCfg0),
		.result      (res0)
	);

	dcc_channel u_chan1 (
		.clk_sys     (clk_sys),
		.sys_rst     (sys_rst),
		.analogResult(analogResult1),
		.ctrlWrData  (sfrWrData),
		.ctrlWr      (sfrWr && (sfrAddr == DCC_ADDR_CTRL1)),
		.modeWrData  (sfrWrData & DCC_MODE_WMASK),
		.modeWr      (sfrWr && (sfrAddr == DCC_ADDR_MODE1)),
		.inselWrData (sfrWrData),
		.inselWr     (sfrWr && (sfrAddr == DCC_ADDR_INSEL1)),
		.ctrlRd      (ctrlRd1),
		.modeRd      (modeRd1),
		.inselRd     (inselRd1),
		.analogCfg   (analogCfg1),
		.result      (res1)
	);

	// registered read data; unmapped addresses read zero
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rdData_q <= 8'h00;
		end else begin
			unique case (sfrAddr)
				DCC_ADDR_CTRL0:  rdData_q <= ctrlRd0;
				DCC_ADDR_CTRL1:  rdData_q <= ctrlRd1;
				DCC_ADDR_MODE0:  rdData_q <= modeRd0;
				DCC_ADDR_MODE1:  rdData_q <= modeRd1;
				DCC_ADDR_INSEL0: rdData_q <= inselRd0;
				DCC_ADDR_INSEL1: rdData_q <= inselRd1;
				default:         rdData_q <= 8'h00;
			endcase
		end
	end

	assign sfrRdData           = rdData_q;
	assign latched_output_zero = res0.latchedOut;
	assign raw_output_zero     = res0.rawOut;
	assign latched_output_one  = res1.latchedOut;
	assign raw_output_one      = res1.rawOut;
	assign comparatorIrq0      = res0.irqReq;
	assign comparatorIrq1      = res1.irqReq;
	assign oscWakeReq          = res0.wakeReq | res1.wakeReq;
	// only channel zero offers a reset source
	assign resetSourceOut      = res0.rawOut;

endmodule

`default_nettype wire

// ### testbench/dcc_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_checker
	import dcc_pkg::*;
(
	input wire logic            clk_sys,
	input wire logic            sys_rst,
	input wire logic [7:0]      sfrAddr,
	input wire logic            sfrWr,
	input wire logic [7:0]      sfrWrData,
	input wire logic [7:0]      sfrRdData,
	input wire logic            analogResult0,
	input wire logic            analogResult1,
	input wire dcc_analog_cfg_t analogCfg0,
	input wire dcc_analog_cfg_t analogCfg1,
	input wire logic            latched_output_zero,
	input wire logic            raw_output_zero,
	input wire logic            raw_output_one,
	input wire logic            oscWakeReq,
	input wire logic            resetSourceOut
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	raw_gate_a: assert property (
		raw_output_zero == (analogResult0 && analogCfg0.enable)) else $error("raw not gated");
	reset_src_a: assert property (resetSourceOut == raw_output_zero)
		else $error("reset source wrong");
	sync_follow_a: assert property (
		$changed(raw_output_zero) ##1 $stable(raw_output_zero) [*4]
		|-> latched_output_zero == raw_output_zero) else $error("latched lags");
	wake_on_a: assert property (
		(analogCfg0.enable && !analogResult0) [*6] |-> oscWakeReq) else $error("no wake");
	wake_off_a: assert property (
		($stable(analogCfg0.enable) && (!analogCfg0.enable || raw_output_zero)
		&& $stable(analogCfg1.enable) && (!analogCfg1.enable || raw_output_one)) [*6]
		|-> !oscWakeReq) else $error("stray wake");
	mode_rd_a: assert property (
		sfrWr && sfrAddr == DCC_ADDR_MODE1 ##1 sfrAddr == DCC_ADDR_MODE1
		|=> sfrRdData == ($past(sfrWrData, 2) & DCC_MODE_WMASK)) else $error("mode read");
	enable_cfg_a: assert property (
		sfrWr && sfrAddr == DCC_ADDR_CTRL0 |=> analogCfg0.enable == $past(sfrWrData[7]))
		else $error("enable wrong");
	pos_sel_a: assert property (
		sfrWr && sfrAddr == DCC_ADDR_INSEL0 && sfrWrData[3:2] != 2'b11 |=> analogCfg0.posValid
		&& analogCfg0.posPinIdx == {$past(sfrWrData[3:0]), 1'b0}) else $error("pos pin");
endmodule
`default_nettype wire

// ### testbench/dcc_comparator_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_comparator_model
	import dcc_pkg::*;
(
	input  wire logic [23:0]     pinLevel,
	input  wire dcc_analog_cfg_t analogCfg0,
	input  wire dcc_analog_cfg_t analogCfg1,
	output logic                 analogResult0,
	output logic                 analogResult1
);
	// unpowered side reads high so missing gating shows
	function automatic logic cmp(input dcc_analog_cfg_t c, input logic [23:0] p);
		if (!(c.enable && c.posValid && c.negValid))
			return 1'b1;
		return p[c.posPinIdx] && !p[c.negPinIdx];
	endfunction
	assign analogResult0 = cmp(analogCfg0, pinLevel);
	assign analogResult1 = cmp(analogCfg1, pinLevel);
endmodule
`default_nettype wire

// ### testbench/tb_dual_comparator_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_comparator_control;
	import dcc_pkg::*;
	logic            clk_sys = 1'b0;
	logic            sys_rst = 1'b1;
	logic            sfrWr = 1'b0;
	logic [7:0]      sfrAddr = 8'h00;
	logic [7:0]      sfrWrData = 8'h00;
	logic [23:0]     pinLevel = 24'h000000;
	logic [7:0]      sfrRdData;
	logic            analogResult0, analogResult1, latched_output_zero, raw_output_zero;
	logic            latched_output_one, raw_output_one, comparatorIrq0, comparatorIrq1;
	logic            oscWakeReq, resetSourceOut;
	dcc_analog_cfg_t analogCfg0, analogCfg1, c;
	int              err_count = 0;
	int              comparisons = 0;
	always #5 clk_sys = ~clk_sys;
	dual_comparator_control u_dual_comparator_control (.clk_sys, .sys_rst, .sfrAddr, .sfrWr,
		.sfrWrData, .sfrRdData, .analogResult0, .analogResult1, .analogCfg0, .analogCfg1,
		.latched_output_zero, .raw_output_zero, .latched_output_one, .raw_output_one,
		.comparatorIrq0, .comparatorIrq1, .oscWakeReq, .resetSourceOut);
	dcc_comparator_model u_dcc_comparator_model (.pinLevel, .analogCfg0, .analogCfg1,
		.analogResult0, .analogResult1);
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (err_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys) #1;
		sfrAddr = a;
		sfrWrData = d;
		sfrWr = 1'b1;
		@(posedge clk_sys) #1;
		sfrWr = 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys) #1;
		sfrAddr = a;
		@(posedge clk_sys) #1;
		check(sfrRdData, exp);
	endtask
	function automatic logic [7:0] adr(input int ch, input int k);
		logic [7:0] t[6] = '{DCC_ADDR_CTRL0, DCC_ADDR_MODE0, DCC_ADDR_INSEL0,
			DCC_ADDR_CTRL1, DCC_ADDR_MODE1, DCC_ADDR_INSEL1};
		return t[ch * 3 + k];
	endfunction
	function automatic logic [2:0] outs(input int ch);
		c = ch ? analogCfg1 : analogCfg0;
		if (ch)
			return {raw_output_one, latched_output_one, comparatorIrq1};
		return {raw_output_zero, latched_output_zero, comparatorIrq0};
	endfunction
	task automatic t_reset();
		for (int ch = 0; ch < 2; ch++) begin
			rdc(adr(ch, 0), DCC_CTRL_RST);
			rdc(adr(ch, 1), DCC_MODE_RST);
			rdc(adr(ch, 2), DCC_INSEL_RST);
		end
		wr(8'h90, 8'h5a);
		rdc(8'h90, 8'h00);
		check(oscWakeReq, 1'b0);
	endtask
	task automatic t_cfg(input int ch);
		logic [4:0] hys[4] = '{DCC_HYS_OFF, DCC_HYS_5MV, DCC_HYS_10MV, DCC_HYS_20MV};
		for (int i = 0; i < 16; i++) begin
			wr(adr(ch, 2), {i[3:0], 4'hf - i[3:0]});
			void'(outs(ch));
			check(c.negValid, i < 12);
			check(c.posValid, i > 3);
			if (i < 12)
				check(c.negPinIdx, 8'(2 * i + 1));
			if (i > 3)
				check(c.posPinIdx, 8'(30 - 2 * i));
		end
		for (int h = 0; h < 4; h++) begin
			wr(adr(ch, 0), {4'h0, h[1:0], h[1:0]});
			wr(adr(ch, 1), 8'hcc | 8'(h));
			void'(outs(ch));
			check(c.hysPosMv, hys[h]);
			check(c.hysNegMv, hys[h]);
			check(c.responseMode, h[1:0]);
			rdc(adr(ch, 1), 8'(h));
		end
	endtask
	task automatic t_edge(input int ch);
		pinLevel = 24'h000000;
		wr(adr(ch, 2), 8'h10);
		wr(adr(ch, 1), 8'h32);
		wr(adr(ch, 0), 8'h80);
		#80;
		wr(adr(ch, 0), 8'h80);
		check(oscWakeReq, 1'b1);
		check(outs(ch), 3'b000);
		pinLevel[0] = 1'b1;
		#80;
		check(outs(ch), 3'b111);
		check(oscWakeReq, 1'b0);
		rdc(adr(ch, 0), 8'he0);
		pinLevel[0] = 1'b0;
		#80;
		rdc(adr(ch, 0), 8'hb0);
		wr(adr(ch, 0), 8'h90);
		wr(adr(ch, 1), 8'h20);
		check(outs(ch), 3'b000);
		wr(adr(ch, 1), 8'h10);
		check(outs(ch), 3'b001);
		wr(adr(ch, 0), 8'hcf);
		rdc(adr(ch, 0), 8'h8f);
		pinLevel[0] = 1'b1;
		#80;
		check(outs(ch), 3'b110);
		wr(adr(ch, 0), 8'h00);
		check(outs(ch) >> 2, 3'b000);
		#80;
		check(outs(ch) >> 1, 3'b000);
		wr(adr(ch, 0), 8'h80);
		// flag clear lands on the edge that sets the rising flag
		@(posedge clk_sys);
		wr(adr(ch, 0), 8'h80);
		rdc(adr(ch, 0), 8'he0);
		wr(adr(ch, 0), 8'h00);
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		t_reset();
		for (int ch = 0; ch < 2; ch++) begin
			t_cfg(ch);
			t_edge(ch);
		end
		finish_test();
	end
	initial begin
		#100000;
		err_count++;
		finish_test();
	end
endmodule
bind dual_comparator_control dcc_checker u_dcc_checker (.clk_sys, .sys_rst, .sfrAddr, .sfrWr,
	.sfrWrData, .sfrRdData, .analogResult0, .analogResult1, .analogCfg0, .analogCfg1,
	.latched_output_zero, .raw_output_zero, .raw_output_one, .oscWakeReq, .resetSourceOut);
`default_nettype wire
